// file: pkg/jac_pkg.sv
// Package of constants and types for the jitter attenuator control registers
package jac_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int          JAC_NUM_CH    = 3;
  localparam logic [7:0]  JAC_OFF_CH0   = 8'h07;
  localparam logic [7:0]  JAC_OFF_CH1   = 8'h0f;
  localparam logic [7:0]  JAC_OFF_CH2   = 8'h17;

  // ----------------------------------------
  // Field layout and reset value
  // ----------------------------------------
  localparam int          JAC_FIELD_W   = 5;
  localparam int          JAC_BIT_DLO   = 0;
  localparam int          JAC_BIT_PATH  = 1;
  localparam int          JAC_BIT_DHI   = 2;
  localparam int          JAC_BIT_CLR   = 3;
  localparam int          JAC_BIT_FRD   = 4;
  localparam logic [7:0]  JAC_RESET_VAL = 8'h03;
  // Suggested setting for chained line testing
  localparam logic [7:0]  JAC_DAISY_VAL = 8'h06;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } jac_bus_req_t;

  typedef struct packed {
    logic fast_recovery_enable;
    logic attenuator_clear;
    logic fifo_depth_sel_hi;
    logic attenuator_path_select;
    logic fifo_depth_sel_lo;
  } jac_chan_cfg_t;

endpackage

// file: rtl/jac_chan_reg.sv
// One channel's read/write control field
`timescale 1ns/1ps
`default_nettype none

module jac_chan_reg (
  // Clock and reset
  input  wire logic                            clk_sys,
  input  wire logic                            reset_n,
  // Write side
  input  wire logic                            wr_en,
  input  wire logic [jac_pkg::JAC_FIELD_W-1:0] wdata,
  // Stored field
  output logic      [jac_pkg::JAC_FIELD_W-1:0] field_q
);

  // RULE3 reset value
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      field_q <= jac_pkg::JAC_RESET_VAL[jac_pkg::JAC_FIELD_W-1:0];
    end else if (wr_en) begin
      field_q <= wdata;
    end
  end

endmodule

`default_nettype wire

// file: rtl/jac_regs.sv
// Jitter attenuator control register bank, three channels
// ----------------------------------------
// Overview of operation
// RULE1: One control register per channel, at 0x07, 0x0f and 0x17.
// RULE2: Bits 7 to 5 read as zero and ignore writes, bits 4 to 0 are read/write.
// RULE3: After reset each register reads 0x03.
// RULE4: Fast recovery can only be switched off in host mode, never in strap mode.
// RULE5: For chained testing software writes 0x06 to select the 32-bit depth.
// RULE6: Software keeps the recovery disable bit at zero to meet switch time and jitter.
// RULE7: While the clear bit is set the channel attenuator is held in its initial state.
// ----------------------------------------
`timescale 1ns/1ps
`default_nettype none

module jac_regs (
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   reset_n,
  // Register port
  input  wire jac_pkg::jac_bus_req_t  bus_req,
  output logic [7:0]                  rd_data,
  // Mode strap, high for host control
  input  wire logic                   host_mode,
  // Per-channel attenuator controls
  output jac_pkg::jac_chan_cfg_t [jac_pkg::JAC_NUM_CH-1:0] chan_cfg
);

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic logic [7:0] chan_offset(input int idx);
    case (idx)
      0:       chan_offset = jac_pkg::JAC_OFF_CH0;
      1:       chan_offset = jac_pkg::JAC_OFF_CH1;
      default: chan_offset = jac_pkg::JAC_OFF_CH2;
    endcase
  endfunction

  function automatic logic chan_hit(input logic [7:0] addr, input int idx);
    chan_hit = (addr == chan_offset(idx));
  endfunction

  logic [jac_pkg::JAC_NUM_CH-1:0] hit;
  logic [jac_pkg::JAC_FIELD_W-1:0] field_q [jac_pkg::JAC_NUM_CH];
  logic                           any_hit;
  logic [7:0]                     rd_mux;
  logic [7:0]                     rd_data_q;
  logic                           strap_taken_q;
  logic                           host_mode_q;

  // RULE1 channel decode
  assign hit[0]  = chan_hit(bus_req.addr, 0);
  assign hit[1]  = chan_hit(bus_req.addr, 1);
  assign hit[2]  = chan_hit(bus_req.addr, 2);
  assign any_hit = |hit;

  // ----------------------------------------
  // Channel registers
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < jac_pkg::JAC_NUM_CH; g++) begin : g_ch
      // RULE2 low five bits only
      jac_chan_reg jac_chan_reg_i (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .wr_en   (bus_req.wr && hit[g]),
        .wdata   (bus_req.wdata[jac_pkg::JAC_FIELD_W-1:0]),
        .field_q (field_q[g])
      );

      // RULE4 strap mode keeps recovery on
      assign chan_cfg[g].fast_recovery_enable =
        !(host_mode_q && field_q[g][jac_pkg::JAC_BIT_FRD]);
      // RULE7 hold while set
      assign chan_cfg[g].attenuator_clear       = field_q[g][jac_pkg::JAC_BIT_CLR];
      assign chan_cfg[g].fifo_depth_sel_hi      = field_q[g][jac_pkg::JAC_BIT_DHI];
      assign chan_cfg[g].attenuator_path_select = field_q[g][jac_pkg::JAC_BIT_PATH];
      assign chan_cfg[g].fifo_depth_sel_lo      = field_q[g][jac_pkg::JAC_BIT_DLO];
    end
  endgenerate

  // ----------------------------------------
  // Mode strap
  // ----------------------------------------
  // Sampled once after release so a later glitch cannot re-enable disabling
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      strap_taken_q <= 1'b0;
      host_mode_q   <= 1'b0;
    end else if (!strap_taken_q) begin
      strap_taken_q <= 1'b1;
      host_mode_q   <= host_mode;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // RULE2 unused bits read zero
  assign rd_mux = hit[0] ? {3'h0, field_q[0]} :
                  hit[1] ? {3'h0, field_q[1]} :
                  hit[2] ? {3'h0, field_q[2]} : 8'h00;

  // Data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rd_data_q <= 8'h00;
    end else begin
      rd_data_q <= bus_req.rd ? rd_mux : 8'h00;
    end
  end

  assign rd_data = rd_data_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence s_rd_ch1;
    bus_req.rd && (bus_req.addr == jac_pkg::JAC_OFF_CH1);
  endsequence

  property p_rd_ch1;
    s_rd_ch1 |=> rd_data == {3'h0, $past(field_q[1])};
  endproperty
  a_rd_ch1: assert property (p_rd_ch1) else $error("Channel 1 read mismatch"); // RULE1

  property p_rd_unmapped;
    bus_req.rd && !any_hit |=> rd_data == 8'h00;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("Unmapped read not zero"); // RULE1

  property p_upper_zero;
    rd_data[7:5] == 3'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("Unused bits read nonzero"); // RULE2

  sequence s_wr_ch2;
    bus_req.wr && (bus_req.addr == jac_pkg::JAC_OFF_CH2);
  endsequence

  property p_wr_ch2;
    s_wr_ch2 |=> field_q[2] == $past(bus_req.wdata[4:0]);
  endproperty
  a_wr_ch2: assert property (p_wr_ch2) else $error("Channel 2 write lost"); // RULE2

  property p_reset_val;
    $rose(reset_n) |-> field_q[0] == jac_pkg::JAC_RESET_VAL[4:0] &&
      field_q[1] == jac_pkg::JAC_RESET_VAL[4:0] && field_q[2] == jac_pkg::JAC_RESET_VAL[4:0];
  endproperty
  a_reset_val: assert property (@(posedge clk_sys) p_reset_val)
    else $error("Reset value wrong"); // RULE3

  property p_strap_keep;
    strap_taken_q && !host_mode_q |-> chan_cfg[0].fast_recovery_enable &&
      chan_cfg[1].fast_recovery_enable && chan_cfg[2].fast_recovery_enable;
  endproperty
  a_strap_keep: assert property (p_strap_keep) else $error("Recovery off in strap mode"); // RULE4

  property p_host_off;
    strap_taken_q && host_mode_q && field_q[0][4] |-> !chan_cfg[0].fast_recovery_enable;
  endproperty
  a_host_off: assert property (p_host_off) else $error("Host disable ignored"); // RULE4

  property p_clear_hold;
    chan_cfg[0].attenuator_clear && !(bus_req.wr && hit[0])
      |=> chan_cfg[0].attenuator_clear;
  endproperty
  a_clear_hold: assert property (p_clear_hold) else $error("Clear dropped by itself"); // RULE7

  sequence s_rd_ch0;
    bus_req.rd && (bus_req.addr == jac_pkg::JAC_OFF_CH0);
  endsequence

  property p_rd_ch0;
    s_rd_ch0 |=> rd_data == {3'h0, $past(field_q[0])};
  endproperty
  a_rd_ch0: assert property (p_rd_ch0) else $error("Channel 0 read mismatch"); // RULE1

  sequence s_rd_ch2;
    bus_req.rd && (bus_req.addr == jac_pkg::JAC_OFF_CH2);
  endsequence

  property p_rd_ch2;
    s_rd_ch2 |=> rd_data == {3'h0, $past(field_q[2])};
  endproperty
  a_rd_ch2: assert property (p_rd_ch2) else $error("Channel 2 read mismatch"); // RULE1

  // Read data must not linger past its one cycle
  property p_rd_idle;
    !bus_req.rd |=> rd_data == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("Read data without a read"); // RULE2

  sequence s_wr_ch0;
    bus_req.wr && (bus_req.addr == jac_pkg::JAC_OFF_CH0);
  endsequence

  property p_wr_ch0;
    s_wr_ch0 |=> field_q[0] == $past(bus_req.wdata[4:0]);
  endproperty
  a_wr_ch0: assert property (p_wr_ch0) else $error("Channel 0 write lost"); // RULE2

  sequence s_wr_ch1;
    bus_req.wr && (bus_req.addr == jac_pkg::JAC_OFF_CH1);
  endsequence

  property p_wr_ch1;
    s_wr_ch1 |=> field_q[1] == $past(bus_req.wdata[4:0]);
  endproperty
  a_wr_ch1: assert property (p_wr_ch1) else $error("Channel 1 write lost"); // RULE2

  // Writes elsewhere must leave a channel alone
  property p_hold_ch1;
    !(bus_req.wr && hit[1]) |=> $stable(field_q[1]);
  endproperty
  a_hold_ch1: assert property (p_hold_ch1) else $error("Channel 1 write leaked"); // RULE2

  // Strap is frozen once taken
  property p_strap_latch;
    strap_taken_q |=> strap_taken_q && $stable(host_mode_q);
  endproperty
  a_strap_latch: assert property (p_strap_latch) else $error("Strap moved after reset"); // RULE4

  property p_clear_release;
    bus_req.wr && hit[0] && !bus_req.wdata[jac_pkg::JAC_BIT_CLR]
      |=> !chan_cfg[0].attenuator_clear;
  endproperty
  a_clear_release: assert property (p_clear_release) else $error("Clear not released"); // RULE7

endmodule

`default_nettype wire

// file: verification/jac_regs_tb.sv
// Self-checking bench for the jitter attenuator control register bank
`timescale 1ns/1ps
`default_nettype none

module jac_regs_tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic                                             clk_sys;
  logic                                             reset_n;
  jac_pkg::jac_bus_req_t                            bus_req;
  logic [7:0]                                       rd_data;
  logic                                             host_mode;
  jac_pkg::jac_chan_cfg_t [jac_pkg::JAC_NUM_CH-1:0] chan_cfg;
  logic [7:0]                                       shadow [3];
  logic [7:0]                                       offs [3];
  logic [7:0]                                       corner [4];
  logic [31:0]                                      seed;
  int                                               k;
  int                                               errors;
  int                                               tests_run;

  jac_regs jac_regs_i (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .bus_req   (bus_req),
    .rd_data   (rd_data),
    .host_mode (host_mode),
    .chan_cfg  (chan_cfg)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] xorshift(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Disable bit only counts when the strap chose host control
  function automatic logic [7:0] cfg_of(input logic [7:0] v, input logic hm);
    return {3'h0, ~(hm & v[4]), v[3:0]};
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic do_reset(input logic hm);
    reset_n   <= 1'b0;
    host_mode <= hm;
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    for (int i = 0; i < 3; i++) shadow[i] = jac_pkg::JAC_RESET_VAL;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys);
    bus_req <= '0;
    for (int i = 0; i < 3; i++) if (offs[i] == a) shadow[i] = d & 8'h1f;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_sys);
    bus_req <= '0;
    #1;
    check(rd_data, exp);
  endtask

  task automatic chk_all(input logic hm);
    for (int i = 0; i < 3; i++) begin
      rd_chk(offs[i], shadow[i]);
      check({3'h0, chan_cfg[i]}, cfg_of(shadow[i], hm));
    end
  endtask

  task automatic print_verdict();
    $display("Checks run %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    reset_n   = 1'b0;
    host_mode = 1'b1;
    bus_req   = '0;
    errors    = 0;
    tests_run = 0;
    seed      = 32'h82bb;
    offs      = '{jac_pkg::JAC_OFF_CH0, jac_pkg::JAC_OFF_CH1, jac_pkg::JAC_OFF_CH2};
    corner    = '{8'h1f, 8'he0, 8'hff, 8'h08};
    do_reset(1'b1);
    chk_all(1'b1);
    rd_chk(8'h08, 8'h00);
    @(posedge clk_sys);
    #1;
    check(rd_data, 8'h00);
    // Near-miss addresses must not alias onto a channel
    wr(8'h06, 8'hff);
    wr(8'h1f, 8'hff);
    chk_all(1'b1);
    for (int c = 0; c < 4; c++) begin
      for (int i = 0; i < 3; i++) wr(offs[i], corner[c]);
      chk_all(1'b1);
    end
    for (int n = 0; n < 30; n++) begin
      seed = xorshift(seed);
      k    = int'(seed[15:8]) % 3;
      wr(offs[k], seed[7:0]);
      chk_all(1'b1);
    end
    for (int i = 0; i < 3; i++) wr(offs[i], jac_pkg::JAC_DAISY_VAL);
    chk_all(1'b1);
    for (int i = 0; i < 3; i++) check({7'h0, chan_cfg[i].fast_recovery_enable}, 8'h01);
    // Strap mode: later strap changes are ignored until the next reset
    do_reset(1'b0);
    repeat (2) @(posedge clk_sys);
    host_mode <= 1'b1;
    for (int i = 0; i < 3; i++) wr(offs[i], 8'h10);
    chk_all(1'b0);
    print_verdict();
  end
endmodule

`default_nettype wire
